//--- hw/sar_pkg.sv
/*
 * Shared constants and types for the converter sequencer: cycle counts,
 * reset values, state encoding and the stereo output word carrier.
 * Assumes a 125 MHz core clock and a 16 MHz crystal arriving on a pin.
 */
package sar_pkg;
    // core clock rate, used to turn times into cycle counts
    localparam int CORE_MHZ = 125;

    // times in ns, cycles derived with least times rounded up
    localparam int DATA_SETUP_NS = 16;
    localparam int LATCH_PULSE_NS = 32;
    localparam int SETTLE_MIN_NS = 320;
    localparam int SETTLE_STEP_NS = 64;
    localparam int DAC_SETTLE_NS = 1600;
    localparam int SETUP_CYC = (DATA_SETUP_NS * CORE_MHZ + 999) / 1000;
    localparam int PULSE_CYC = (LATCH_PULSE_NS * CORE_MHZ + 999) / 1000;
    localparam int SETTLE_MIN_CYC = (SETTLE_MIN_NS * CORE_MHZ + 999) / 1000;
    localparam int SETTLE_STEP_CYC = (SETTLE_STEP_NS * CORE_MHZ + 999) / 1000;
    localparam int DAC_SETTLE_CYC = (DAC_SETTLE_NS * CORE_MHZ + 999) / 1000;

    // crystal edge divider: 16 MHz / 512 = 31.25 kHz word strobe
    localparam int XTAL_CNT_W = 9;
    localparam int CPU_CLK_BIT = 1;     // 16 MHz / 4 = 4 MHz
    localparam int SER_CLK_BIT = 2;     // 4 MHz / 2 = 2 MHz
    localparam int BAUD_CLK_BIT = 4;    // 16 MHz / 32 = 500 kHz
    localparam int STROBE_BIT = 8;      // 16 MHz / 512 = 31.25 kHz

    // converter word geometry
    localparam int WORD_W = 16;
    localparam int TRIAL_COUNT = 16;
    localparam int CNT_W = 8;
    localparam logic [3:0] MSB_INDEX = 4'hF;
    localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
    localparam logic [XTAL_CNT_W-1:0] XTAL_CNT_RESET = 9'h000;

    // sequencer states, gray coded in declaration order; the ST_DECIDE to ST_TRIAL loop back changes three bits
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_TRIAL = 4'h1,
        ST_PULSE = 4'h3,
        ST_SETTLE = 4'h2,
        ST_DECIDE = 4'h6,
        ST_LEFT = 4'h7,
        ST_LPULSE = 4'h5,
        ST_LSETTLE = 4'h4,
        ST_RIGHT = 4'hC,
        ST_RPULSE = 4'hD,
        ST_RSETTLE = 4'hF
    } sar_state_t;

    // left and right words to be played out each word period
    typedef struct packed {
        logic [WORD_W-1:0] left;
        logic [WORD_W-1:0] right;
    } sar_dac_pair_t;
endpackage

//--- hw/sar_clk_div.sv
/*
 * Crystal divider: counts 16 MHz crystal edges in the core domain and
 * produces the processor clock, serial controller clock, baud reference
 * and word strobe as registered levels.
 * Assumes the crystal is far slower than core_clk so every edge is seen.
 */
`timescale 1ns/1ns
`default_nettype none
module sar_clk_div (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic xtal_in,
    output logic cpu_clk,
    output logic serial_ctrl_clk,
    output logic prog_clk_out,
    output logic word_strobe_n
);
    import sar_pkg::*;

    logic xtal_meta_q;
    logic xtal_sync_q;
    logic xtal_prev_q;
    logic [XTAL_CNT_W-1:0] cnt_q;
    wire xtal_rise = xtal_sync_q & ~xtal_prev_q;

    // two-flop synchroniser, then edge history for the rise detector
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            xtal_meta_q <= 1'b0;
            xtal_sync_q <= 1'b0;
            xtal_prev_q <= 1'b0;
        end else begin
            xtal_meta_q <= xtal_in;
            xtal_sync_q <= xtal_meta_q;
            xtal_prev_q <= xtal_sync_q;
        end
    end

    // free running crystal edge count; wraps every 512 edges
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= XTAL_CNT_RESET;
        end else if (xtal_rise) begin
            cnt_q <= cnt_q + 9'h001;
        end
    end

    // outputs straight from counter bits, which are flip-flops
    assign cpu_clk = cnt_q[CPU_CLK_BIT];
    assign serial_ctrl_clk = cnt_q[SER_CLK_BIT];
    assign prog_clk_out = cnt_q[BAUD_CLK_BIT];
    assign word_strobe_n = cnt_q[STROBE_BIT];
endmodule
`default_nettype wire

//--- hw/sar_sequencer.sv
/*
 * Converter sequencer: per word period runs a sixteen-step successive
 * approximation through the external DAC and comparator, then plays the
 * left and right words out and opens each deglitch switch.
 * Assumes external latches capture audio_bus on the rising edge of
 * conv_latch_clk and the comparator output arrives asynchronously.
 */
// Overview of operation
// - word strobe runs at 31.25 kHz; its falling edge starts each cycle
// - sample-hold goes low at strobe fall to hold input during conversion
// - each trial word is driven on the audio bus, latched on clock rise
// - comparator bit is sampled after each trial to steer the next trial
// - a conversion takes sixteen trials, each with a comparator decision
// - settle time between latch pulses shrinks as the trial bit gets smaller
// - seventeenth latch pulse after strobe fall carries the left output word
// - after DAC settling, left deglitch goes high
// - last latch pulse of the period carries the right output word
// - after the right word is latched, right deglitch goes high
// - crystal 16 MHz is divided to the 4 MHz processor clock
// - programmable clock output gives a 500 kHz baud reference
// - processor clock is halved to a 2 MHz serial controller clock
`timescale 1ns/1ns
`default_nettype none
module sar_sequencer (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic xtal_in,
    input wire logic serial_compare_in,
    input wire sar_pkg::sar_dac_pair_t dac_words,
    output logic [sar_pkg::WORD_W-1:0] audio_bus,
    output logic audio_bus_oe,
    output logic conv_latch_clk,
    output logic sample_hold_n,
    output logic left_deglitch,
    output logic right_deglitch,
    output logic [sar_pkg::WORD_W-1:0] adc_word,
    output logic adc_valid,
    output logic word_strobe_n,
    output logic cpu_clk,
    output logic serial_ctrl_clk,
    output logic prog_clk_out
);
    import sar_pkg::*;

    // settle count for a trial: larger bits move the DAC more
    function automatic logic [CNT_W-1:0] settle_for(input logic [3:0] bit_idx);
        settle_for = CNT_W'(SETTLE_MIN_CYC) + CNT_W'(bit_idx) * CNT_W'(SETTLE_STEP_CYC);
    endfunction

    sar_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [3:0] bit_q, bit_d;
    logic [WORD_W-1:0] result_q, result_d;
    logic [WORD_W-1:0] bus_q, bus_d;
    logic oe_q, oe_d;
    logic latch_q, latch_d;
    logic hold_n_q, hold_n_d;
    logic ldeg_q, ldeg_d;
    logic rdeg_q, rdeg_d;
    logic [WORD_W-1:0] adc_q, adc_d;
    logic valid_q, valid_d;
    logic strobe_prev_q;
    logic cmp_meta_q;
    logic cmp_sync_q;
    logic strobe_n;

    sar_clk_div u_div (
        .core_clk(core_clk),
        .rst(rst),
        .xtal_in(xtal_in),
        .cpu_clk(cpu_clk),
        .serial_ctrl_clk(serial_ctrl_clk),
        .prog_clk_out(prog_clk_out),
        .word_strobe_n(strobe_n)
    );

    // strobe comes from a same-domain flop, so no synchroniser is needed
    wire strobe_fall = strobe_prev_q & ~strobe_n;
    wire cnt_done = (cnt_q == CNT_RESET);
    wire [CNT_W-1:0] cnt_dec = cnt_q - 8'h01;
    wire [WORD_W-1:0] bit_mask = WORD_W'(1) << bit_q;
    wire [WORD_W-1:0] trial_word = result_q | bit_mask;
    wire [WORD_W-1:0] kept_word = cmp_sync_q ? trial_word : result_q;

    // comparator is asynchronous to core_clk: two flops before use
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cmp_meta_q <= 1'b0;
            cmp_sync_q <= 1'b0;
            strobe_prev_q <= 1'b0;          // strobe idles low after reset; a high here fakes a fall
        end else begin
            cmp_meta_q <= serial_compare_in;
            cmp_sync_q <= cmp_meta_q;
            strobe_prev_q <= strobe_n;
        end
    end

    // next-state logic; a strobe fall restarts the sequence from any state
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_done ? CNT_RESET : cnt_dec;
        bit_d = bit_q;
        result_d = result_q;
        bus_d = bus_q;
        oe_d = oe_q;
        latch_d = latch_q;
        hold_n_d = hold_n_q;
        ldeg_d = ldeg_q;
        rdeg_d = rdeg_q;
        adc_d = adc_q;
        valid_d = 1'b0;
        if (strobe_fall) begin
            state_d = ST_TRIAL;
            hold_n_d = 1'b0;
            ldeg_d = 1'b0;
            rdeg_d = 1'b0;
            bit_d = MSB_INDEX;
            result_d = WORD_RESET;
            bus_d = WORD_RESET | (WORD_W'(1) << MSB_INDEX);
            oe_d = 1'b1;
            latch_d = 1'b0;
            cnt_d = CNT_W'(SETUP_CYC - 1);
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    oe_d = 1'b0;
                end
                ST_TRIAL: if (cnt_done) begin
                    latch_d = 1'b1;
                    cnt_d = CNT_W'(PULSE_CYC - 1);
                    state_d = ST_PULSE;
                end
                ST_PULSE: if (cnt_done) begin
                    latch_d = 1'b0;
                    cnt_d = settle_for(bit_q);
                    state_d = ST_SETTLE;
                end
                ST_SETTLE: if (cnt_done) begin
                    state_d = ST_DECIDE;
                end
                ST_DECIDE: begin
                    result_d = kept_word;
                    if (bit_q == 4'h0) begin
                        // all sixteen trials done: present result, release hold
                        adc_d = kept_word;
                        valid_d = 1'b1;
                        hold_n_d = 1'b1;
                        bus_d = dac_words.left;
                        cnt_d = CNT_W'(SETUP_CYC - 1);
                        state_d = ST_LEFT;
                    end else begin
                        bit_d = bit_q - 4'h1;
                        bus_d = kept_word | (WORD_W'(1) << (bit_q - 4'h1));
                        cnt_d = CNT_W'(SETUP_CYC - 1);
                        state_d = ST_TRIAL;
                    end
                end
                ST_LEFT: if (cnt_done) begin
                    latch_d = 1'b1;
                    cnt_d = CNT_W'(PULSE_CYC - 1);
                    state_d = ST_LPULSE;
                end
                ST_LPULSE: if (cnt_done) begin
                    latch_d = 1'b0;
                    cnt_d = CNT_W'(DAC_SETTLE_CYC - 1);
                    state_d = ST_LSETTLE;
                end
                ST_LSETTLE: if (cnt_done) begin
                    ldeg_d = 1'b1;
                    bus_d = dac_words.right;
                    cnt_d = CNT_W'(SETUP_CYC - 1);
                    state_d = ST_RIGHT;
                end
                ST_RIGHT: if (cnt_done) begin
                    latch_d = 1'b1;
                    cnt_d = CNT_W'(PULSE_CYC - 1);
                    state_d = ST_RPULSE;
                end
                ST_RPULSE: if (cnt_done) begin
                    latch_d = 1'b0;
                    cnt_d = CNT_W'(DAC_SETTLE_CYC - 1);
                    state_d = ST_RSETTLE;
                end
                ST_RSETTLE: if (cnt_done) begin
                    rdeg_d = 1'b1;
                    oe_d = 1'b0;                    // free the shared bus
                    state_d = ST_IDLE;
                end
                default: begin
                    state_d = ST_IDLE;
                    oe_d = 1'b0;
                    latch_d = 1'b0;
                end
            endcase
        end
    end

    // sequencer registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            cnt_q <= CNT_RESET;
            bit_q <= MSB_INDEX;
            result_q <= WORD_RESET;
            bus_q <= WORD_RESET;
            oe_q <= 1'b0;
            latch_q <= 1'b0;
            hold_n_q <= 1'b1;
            ldeg_q <= 1'b0;
            rdeg_q <= 1'b0;
            adc_q <= WORD_RESET;
            valid_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            bit_q <= bit_d;
            result_q <= result_d;
            bus_q <= bus_d;
            oe_q <= oe_d;
            latch_q <= latch_d;
            hold_n_q <= hold_n_d;
            ldeg_q <= ldeg_d;
            rdeg_q <= rdeg_d;
            adc_q <= adc_d;
            valid_q <= valid_d;
        end
    end

    // all outputs come from flip-flops
    assign audio_bus = bus_q;
    assign audio_bus_oe = oe_q;
    assign conv_latch_clk = latch_q;
    assign sample_hold_n = hold_n_q;
    assign left_deglitch = ldeg_q;
    assign right_deglitch = rdeg_q;
    assign adc_word = adc_q;
    assign adc_valid = valid_q;
    assign word_strobe_n = strobe_n;
endmodule
`default_nettype wire

//--- verif/sar_seq_properties.sv
/* checker: timing relations at the converter sequencer ports.
   assumes a bind onto sar_sequencer and the single core clock domain. */
`timescale 1ns/1ns
`default_nettype none
module sar_seq_properties (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [sar_pkg::WORD_W-1:0] audio_bus,
    input wire logic audio_bus_oe,
    input wire logic conv_latch_clk,
    input wire logic sample_hold_n,
    input wire logic left_deglitch,
    input wire logic right_deglitch,
    input wire logic adc_valid,
    input wire logic word_strobe_n
);
    import sar_pkg::*;
    logic [4:0] pcnt_q;
    logic [11:0] gap_q, last_q, since_q;
    logic clk_d1_q, ws_d1_q;
    wire rise_w = conv_latch_clk & ~clk_d1_q;
    // pulse count per strobe period, gap between rises and time since a pulse ended
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            {pcnt_q, gap_q, last_q, since_q, clk_d1_q, ws_d1_q} <= '0;
        end else begin
            clk_d1_q <= conv_latch_clk;
            ws_d1_q <= word_strobe_n;
            pcnt_q <= (ws_d1_q & ~word_strobe_n) ? 5'h00 : pcnt_q + 5'(rise_w);
            gap_q <= rise_w ? 12'h001 : gap_q + 12'h001;
            last_q <= rise_w ? gap_q : last_q;
            since_q <= conv_latch_clk ? 12'h000 : since_q + 12'h001;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_hold_on_strobe: assert property ($fell(word_strobe_n) |=> !sample_hold_n)
        else $error("sample hold not low after strobe fall");
    a_first_trial_msb: assert property ($fell(word_strobe_n) |=> audio_bus == 16'h8000 && audio_bus_oe
        && !left_deglitch && !right_deglitch) else $error("first trial word wrong");
    a_word_before_latch: assert property ($rose(conv_latch_clk) |-> audio_bus_oe
        && audio_bus == $past(audio_bus, 2)) else $error("bus word not set up before latch");
    a_latch_width: assert property ($rose(conv_latch_clk) |-> conv_latch_clk[*4] ##1 !conv_latch_clk)
        else $error("latch pulse width wrong");
    a_word_in_pulse: assert property (conv_latch_clk |-> $stable(audio_bus))
        else $error("bus word moved during latch pulse");
    a_hold_in_conv: assert property (conv_latch_clk && pcnt_q < 16 |-> !sample_hold_n)
        else $error("sample hold released during conversion");
    a_sixteen_trials: assert property (adc_valid |-> pcnt_q == 16)
        else $error("result not after sixteen trials");
    a_shrinking_gap: assert property (rise_w && pcnt_q inside {[2:15]} |-> gap_q < last_q)
        else $error("trial interval did not shrink");
    a_left_settle: assert property ($rose(left_deglitch) |-> pcnt_q == 17 && since_q >= 196
        && since_q <= 204) else $error("left deglitch timing wrong");
    a_right_settle: assert property ($rose(right_deglitch) |-> pcnt_q == 18 && since_q >= 196
        && since_q <= 204) else $error("right deglitch timing wrong");
    a_no_extra_pulse: assert property (rise_w |-> pcnt_q < 18)
        else $error("latch pulse after the right word");
    c_result: cover property (adc_valid);
    c_left: cover property ($rose(left_deglitch));
    c_right: cover property ($rose(right_deglitch));
endmodule
bind sar_sequencer sar_seq_properties chk_u (.core_clk(core_clk), .rst(rst), .audio_bus(audio_bus),
    .audio_bus_oe(audio_bus_oe), .conv_latch_clk(conv_latch_clk), .sample_hold_n(sample_hold_n),
    .left_deglitch(left_deglitch), .right_deglitch(right_deglitch), .adc_valid(adc_valid),
    .word_strobe_n(word_strobe_n));
`default_nettype wire

//--- verif/sar_dac_model.sv
/* partner: two byte latches feeding the DAC, and the comparator.
   assumes the bench gives the held analog level as a 16-bit code. */
`timescale 1ns/1ns
`default_nettype none
module sar_dac_model #(
    parameter int COMP_NS = 40
) (
    input wire logic conv_latch_clk,
    input wire logic word_strobe_n,
    input wire logic [15:0] audio_bus,
    input wire logic [15:0] ain,
    output logic [15:0] dac_q,
    output logic [4:0] pulses_q,
    output wire logic comp_out
);
    logic cmp_q = 1'b0;
    // both byte latches load on the rising latch clock edge
    always @(posedge conv_latch_clk) begin
        dac_q[7:0] <= audio_bus[7:0];
        dac_q[15:8] <= audio_bus[15:8];
    end
    // pulses since the strobe fell, for the bench to judge
    always @(negedge word_strobe_n or posedge conv_latch_clk) begin
        pulses_q <= conv_latch_clk ? pulses_q + 5'h01 : 5'h00;
    end
    // slow comparator: equal counts as at or above
    always @(ain, dac_q) begin
        cmp_q <= #COMP_NS (ain >= dac_q);
    end
    assign comp_out = cmp_q;
endmodule
`default_nettype wire

//--- verif/sar_converter_sequencer_test.sv
/* testbench: crystal, analog level and output words in; checks results,
   latched words and clock rates. assumes checker and model compiled first. */
`timescale 1ns/1ns
`default_nettype none
module sar_converter_sequencer_test;
    import sar_pkg::*;
    localparam int XTAL_NS = 63; // 1 ns grid cannot hold 62.5
    logic core_clk, rst, xtal_in, comp_w;
    sar_dac_pair_t dac_words;
    logic [WORD_W-1:0] audio_bus, adc_word, ain, dac_w;
    logic audio_bus_oe, conv_latch_clk, sample_hold_n, left_deglitch, right_deglitch;
    logic adc_valid, word_strobe_n, cpu_clk, serial_ctrl_clk, prog_clk_out;
    logic [4:0] pulses_w;
    int err_total, num_checks;
    sar_sequencer dut_u (.core_clk(core_clk), .rst(rst), .xtal_in(xtal_in), .serial_compare_in(comp_w),
        .dac_words(dac_words), .audio_bus(audio_bus), .audio_bus_oe(audio_bus_oe),
        .conv_latch_clk(conv_latch_clk), .sample_hold_n(sample_hold_n), .left_deglitch(left_deglitch),
        .right_deglitch(right_deglitch), .adc_word(adc_word), .adc_valid(adc_valid),
        .word_strobe_n(word_strobe_n), .cpu_clk(cpu_clk), .serial_ctrl_clk(serial_ctrl_clk),
        .prog_clk_out(prog_clk_out));
    sar_dac_model #(.COMP_NS(300)) model_u (.conv_latch_clk(conv_latch_clk), .word_strobe_n(word_strobe_n),
        .audio_bus(audio_bus), .ain(ain), .dac_q(dac_w), .pulses_q(pulses_w), .comp_out(comp_w));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        xtal_in = 1'b0;
        forever begin
            #31 xtal_in = 1'b1;
            #32 xtal_in = 1'b0;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (err_total == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    function automatic logic pick(input int k);
        return k == 0 ? cpu_clk : k == 1 ? serial_ctrl_clk : k == 2 ? prog_clk_out : word_strobe_n;
    endfunction
    // one rise-to-rise period, allowing one core cycle of sync jitter
    task automatic clk_rate(input int k, input int div);
        time t0;
        for (int n = 0; n < 2; n++) begin
            while (pick(k) !== 1'b0) @(posedge core_clk);
            while (pick(k) !== 1'b1) @(posedge core_clk);
            if (n == 0) t0 = $time;
        end
        check(($time - t0 <= div * XTAL_NS + 8) && ($time - t0 + 8 >= div * XTAL_NS), 1'b1);
    endtask
    // one full word period: result, then left and right words at the DAC
    task automatic t_convert(input logic [15:0] a, input logic [15:0] l, input logic [15:0] r);
        int n;
        @(posedge core_clk);
        #1;
        ain = a;
        dac_words = {l, r};
        while (word_strobe_n !== 1'b1) @(posedge core_clk);
        while (word_strobe_n !== 1'b0) @(posedge core_clk);
        @(posedge core_clk);
        check(sample_hold_n, 1'b0);
        for (n = 0; n < 4000 && adc_valid !== 1'b1; n++) @(posedge core_clk);
        check(adc_word, a);
        check(pulses_w, 16);
        check(sample_hold_n, 1'b1);
        while (left_deglitch !== 1'b1) @(posedge core_clk);
        check(pulses_w, 17);
        check(dac_w, l);
        while (right_deglitch !== 1'b1) @(posedge core_clk);
        check(pulses_w, 18);
        check(dac_w, r);
    endtask
    initial begin
        rst = 1'b1;
        ain = 16'h0000;
        dac_words = '0;
        err_total = 0;
        num_checks = 0;
        repeat (12) @(posedge core_clk);
        check({sample_hold_n, word_strobe_n, conv_latch_clk, left_deglitch, right_deglitch}, 5'h10);
        #1 rst = 1'b0;
        clk_rate(0, 4);
        clk_rate(1, 8);
        clk_rate(2, 32);
        clk_rate(3, 512);
        t_convert(16'h0000, 16'hFFFF, 16'h0001);
        t_convert(16'hFFFF, 16'h8000, 16'h7FFF);
        t_convert(16'h8000, 16'h1234, 16'hEDCB);
        t_convert(16'h7FFF, 16'hA5A5, 16'h5A5A);
        give_verdict();
    end
    // watchdog: all scenarios need well under half this span
    initial begin
        #800000;
        err_total++;
        give_verdict();
    end
endmodule
`default_nettype wire
